// ### src/mra_pkg.sv
// package: constants for the modem register access block
// assumes: 32-bit AHB-Lite register bus, 10 MHz hclk
package mra_pkg;
	// register byte offsets
	localparam logic [7:0] MRA_HCR_OFS = 8'h00;
	localparam logic [7:0] MRA_HSR_OFS = 8'h04;
	localparam logic [7:0] MRA_STAT_OFS = 8'h08;
	localparam logic [7:0] MRA_DET_OFS = 8'h0c;
	localparam logic [7:0] MRA_MREG_OFS = 8'h20;
	localparam logic [7:0] MRA_MREG_END = 8'h3c;
	// handshake_control_reg fields
	localparam int MRA_HCR_DTR = 0;
	localparam int MRA_HCR_RTS = 1;
	localparam int MRA_HCR_AUX = 3;
	localparam int MRA_HCR_W = 5;
	localparam logic [4:0] MRA_HCR_RST = 5'h00;
	// handshake_status_reg fields
	localparam int MRA_HSR_CTS = 4;
	localparam int MRA_HSR_DSR = 5;
	localparam int MRA_HSR_RI = 6;
	localparam int MRA_HSR_DCD = 7;
	// status register fields
	localparam int MRA_ST_SINGLE = 0;
	localparam int MRA_ST_MIRQ = 1;
	localparam int MRA_ST_UIRQ = 2;
	localparam int MRA_ST_ADDR = 4;
	localparam int MRA_ST_CS = 8;
	localparam int MRA_ST_PRST = 9;
	// modem register bank
	localparam int MRA_NREG = 8;
	localparam int MRA_DW = 8;
	localparam logic [2:0] MRA_DET_IDX = 3'h1;
	localparam logic [7:0] MRA_MREG_RST = 8'h00;
	// serial bit count per transfer
	localparam logic [3:0] MRA_NBITS = 4'h8;
	// synchronised pin vector layout
	localparam int MRA_P_MODE = 0;
	localparam int MRA_P_ALS = 1;
	localparam int MRA_P_HADDR = 2;
	localparam int MRA_P_CS = 6;
	localparam int MRA_P_CTS = 7;
	localparam int MRA_P_DSR = 8;
	localparam int MRA_P_DCD = 9;
	localparam int MRA_P_RI = 10;
	localparam int MRA_P_SCLK = 11;
	localparam int MRA_P_RD = 12;
	localparam int MRA_P_WR = 13;
	localparam int MRA_P_DIN = 14;
	localparam int MRA_P_MA = 15;
	localparam int MRA_P_DRST = 17;
	localparam int MRA_NPIN = 18;
	localparam logic [17:0] MRA_PIN_RST = 18'h03f83;
endpackage

// ### src/mra_ser_if.sv
// interface: serial command port events and data between top and engine
// assumes: all signals on hclk, pin inputs already synchronised
`timescale 1ns/100ps
interface mra_ser_if;
	logic sclk_fall;
	logic rd_act;
	logic rd_fall;
	logic wr_rise;
	logic din;
	logic [7:0] rdata;
	logic [7:0] wdata;
	logic we;
	logic rd_start;
	logic dout;
	modport top (output sclk_fall, rd_act, rd_fall, wr_rise, din, rdata,
		input wdata, we, rd_start, dout);
	modport eng (input sclk_fall, rd_act, rd_fall, wr_rise, din, rdata,
		output wdata, we, rd_start, dout);
endinterface

// ### src/mra_ser_eng.sv
// serial command port shift engine: byte in on write, byte out on read
// assumes: events are one-cycle pulses on hclk, gated by ce
`timescale 1ns/100ps
module mra_ser_eng (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	mra_ser_if.eng s
);
	import mra_pkg::*;
	logic [7:0] sh_q;
	logic [3:0] cnt_q;
	logic rd_act_q;
	logic rd_end;

	// a finished read leaves the counter full; the next write needs it at zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_act_q <= 1'b0;
		end else if (ce) begin
			rd_act_q <= s.rd_act;
		end
	end

	assign rd_end = rd_act_q && !s.rd_act;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sh_q <= 8'h00;
		end else if (ce) begin
			if (s.rd_fall) begin
				sh_q <= s.rdata;
			end else if (s.sclk_fall && cnt_q < MRA_NBITS) begin
				if (s.rd_act) begin
					sh_q <= {1'b0, sh_q[7:1]};
				end else begin
					sh_q <= {s.din, sh_q[7:1]};
				end
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 4'h0;
		end else if (ce) begin
			if (s.rd_fall || s.wr_rise || rd_end) begin
				cnt_q <= 4'h0;
			end else if (s.sclk_fall && cnt_q < MRA_NBITS) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	assign s.wdata = sh_q;
	assign s.we = s.wr_rise && ce;
	assign s.rd_start = s.rd_fall && ce;
	assign s.dout = sh_q[0];
endmodule

// ### src/mra_top.sv
// modem register access ports: single-port latch/handshake and dual-port
// serial command port, with an AHB-Lite register slave
// assumes: pins are asynchronous to hclk; uart_irq_in and
// modem_detect_flags come from logic on hclk
//
// Overview of operation
// - mode select high gives single-port mode, low gives serial dual-port mode
// - single-port: the host bus configures both UART and modem registers
// - address bits and chip select latch on strobe rising edge
// - bank bit 0 selects UART registers, 1 selects modem registers
// - status bits are complements of active-low handshake input pins
// - active-low DTR and RTS outputs follow control register bits
// - data pin is output while read strobe low, input otherwise
// - serial data shifts on falling edge of the bit clock
// - shifted byte written into addressed register on write strobe rise
// - read strobe low starts read; eight bits out LSB first
// - no read data driven unless read strobe active
// - dual-port: modem interrupt asserts when any detect flag changes
// - modem interrupt holds until detect register read or reset
// - processor reset out is reset input or aux bit D3
// - dual-port: fourth host address pin becomes third modem address line
// - single-port: UART interrupt also asserts on modem interrupt
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
module mra_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic port_mode_select,
	input wire logic addr_latch_strobe_n,
	input wire logic [3:0] host_reg_addr,
	input wire logic chip_select_two_n,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic dcd_n,
	input wire logic ri_n,
	output logic dtr_n,
	output logic rts_n,
	output logic bank_select_addr,
	output logic [2:0] host_reg_sel,
	output logic host_chip_sel,
	input wire logic serial_bit_clock,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [1:0] modem_reg_addr,
	input wire logic ser_data_i,
	output logic ser_data_o,
	output logic ser_data_oe_n,
	input wire logic device_reset_in,
	input wire logic uart_irq_in,
	input wire logic [7:0] modem_detect_flags,
	output logic uart_irq_out,
	output logic modem_irq_out,
	output logic processor_reset_out
);
	import mra_pkg::*;

	logic [MRA_NPIN-1:0] pin_raw;
	logic [MRA_NPIN-1:0] pin_s1_q;
	logic [MRA_NPIN-1:0] pin_s2_q;
	logic [MRA_NPIN-1:0] pin_s3_q;
	logic single;
	logic als_rise;
	logic sclk_fall;
	logic rd_fall;
	logic wr_rise;
	logic [2:0] maddr;
	logic [3:0] lat_addr_q;
	logic lat_cs_q;
	logic [MRA_HCR_W-1:0] hcr_q;
	logic [MRA_DW-1:0] mreg_q [MRA_NREG];
	logic [7:0] det_q;
	logic mirq_q;
	logic det_clr;
	logic [7:0] hsr;
	logic [7:0] ser_rdata;
	logic ap_take;
	logic dp_wr_q;
	logic [7:0] dp_addr_q;
	logic [31:0] rd_d;
	logic [31:0] hrdata_q;
	logic mreg_hit;
	logic [2:0] mreg_idx;
	logic det_rd;
	mra_ser_if ser ();

	// two-flop synchronisers for every pin input
	assign pin_raw = {device_reset_in, modem_reg_addr, ser_data_i, wr_n, rd_n,
		serial_bit_clock, ri_n, dcd_n, dsr_n, cts_n, chip_select_two_n,
		host_reg_addr, addr_latch_strobe_n, port_mode_select};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_q <= MRA_PIN_RST;
			pin_s2_q <= MRA_PIN_RST;
			pin_s3_q <= MRA_PIN_RST;
		end else if (ce) begin
			pin_s1_q <= pin_raw;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	assign single = pin_s2_q[MRA_P_MODE];
	assign als_rise = pin_s2_q[MRA_P_ALS] && !pin_s3_q[MRA_P_ALS];
	assign sclk_fall = !pin_s2_q[MRA_P_SCLK] && pin_s3_q[MRA_P_SCLK];
	assign rd_fall = !single && !pin_s2_q[MRA_P_RD] && pin_s3_q[MRA_P_RD];
	assign wr_rise = !single && pin_s2_q[MRA_P_WR] && !pin_s3_q[MRA_P_WR];
	// fourth host address pin serves as the top modem address line
	assign maddr = {pin_s2_q[MRA_P_HADDR+3], pin_s2_q[MRA_P_MA+1:MRA_P_MA]};

	// single-port address and chip select latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lat_addr_q <= 4'h0;
			lat_cs_q <= 1'b0;
		end else if (ce && single && als_rise) begin
			lat_addr_q <= pin_s2_q[MRA_P_HADDR+3:MRA_P_HADDR];
			lat_cs_q <= !pin_s2_q[MRA_P_CS];
		end
	end

	assign bank_select_addr = lat_addr_q[3];
	assign host_reg_sel = lat_addr_q[2:0];
	assign host_chip_sel = lat_cs_q && single;

	// handshake status mirrors inverted pins
	always_comb begin
		hsr = 8'h00;
		if (single) begin
			hsr[MRA_HSR_CTS] = !pin_s2_q[MRA_P_CTS];
			hsr[MRA_HSR_DSR] = !pin_s2_q[MRA_P_DSR];
			hsr[MRA_HSR_RI] = !pin_s2_q[MRA_P_RI];
			hsr[MRA_HSR_DCD] = !pin_s2_q[MRA_P_DCD];
		end
	end

	// handshake lines are released in dual-port mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dtr_n <= 1'b1;
			rts_n <= 1'b1;
		end else if (ce) begin
			dtr_n <= !(single && hcr_q[MRA_HCR_DTR]);
			rts_n <= !(single && hcr_q[MRA_HCR_RTS]);
		end
	end

	// ahb-lite slave: zero wait states, always okay
	assign ap_take = hsel && hready && htrans[1];
	assign mreg_hit = dp_addr_q >= MRA_MREG_OFS && dp_addr_q <= MRA_MREG_END;
	assign mreg_idx = dp_addr_q[4:2];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_q <= 1'b0;
			dp_addr_q <= 8'h00;
		end else if (ce) begin
			if (hready) begin
				dp_wr_q <= ap_take && hwrite && hsize == 3'h2;
				dp_addr_q <= haddr[7:0];
			end
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		det_rd = 1'b0;
		case (haddr[7:0])
			MRA_HCR_OFS: rd_d[MRA_HCR_W-1:0] = hcr_q;
			MRA_HSR_OFS: rd_d[7:0] = hsr;
			MRA_STAT_OFS: begin
				rd_d[MRA_ST_SINGLE] = single;
				rd_d[MRA_ST_MIRQ] = mirq_q;
				rd_d[MRA_ST_UIRQ] = uart_irq_out;
				rd_d[MRA_ST_ADDR+3:MRA_ST_ADDR] = lat_addr_q;
				rd_d[MRA_ST_CS] = lat_cs_q;
				rd_d[MRA_ST_PRST] = processor_reset_out;
			end
			MRA_DET_OFS: begin
				rd_d[7:0] = det_q;
				det_rd = 1'b1;
			end
			default: begin
				if (haddr[7:0] >= MRA_MREG_OFS && haddr[7:0] <= MRA_MREG_END) begin
					if (haddr[4:2] == MRA_DET_IDX) begin
						rd_d[7:0] = det_q;
						det_rd = 1'b1;
					end else begin
						rd_d[7:0] = mreg_q[haddr[4:2]];
					end
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= 32'h0000_0000;
		end else if (ce && ap_take && !hwrite) begin
			hrdata_q <= rd_d;
		end
	end

	assign hrdata = hrdata_q;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hcr_q <= MRA_HCR_RST;
		end else if (ce && dp_wr_q && dp_addr_q == MRA_HCR_OFS) begin
			hcr_q <= hwdata[MRA_HCR_W-1:0];
		end
	end

	// modem register bank: host bus or serial port writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < MRA_NREG; i++) begin
				mreg_q[i] <= MRA_MREG_RST;
			end
		end else if (ce) begin
			if (ser.we && !single) begin
				mreg_q[maddr] <= ser.wdata;
			end else if (dp_wr_q && mreg_hit) begin
				mreg_q[mreg_idx] <= hwdata[7:0];
			end
		end
	end

	// detect flags and sticky modem interrupt
	assign det_clr = (ser.rd_start && !single && maddr == MRA_DET_IDX)
		|| (ce && ap_take && !hwrite && det_rd);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			det_q <= 8'h00;
			mirq_q <= 1'b0;
		end else if (ce) begin
			det_q <= modem_detect_flags;
			if (det_q != modem_detect_flags) begin
				mirq_q <= 1'b1;
			end else if (det_clr) begin
				mirq_q <= 1'b0;
			end
		end
	end

	assign modem_irq_out = mirq_q && !single;
	assign uart_irq_out = uart_irq_in || (mirq_q && single);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			processor_reset_out <= 1'b1;
		end else if (ce) begin
			processor_reset_out <= pin_s2_q[MRA_P_DRST]
				|| hcr_q[MRA_HCR_AUX];
		end
	end

	// serial command port
	assign ser_rdata = maddr == MRA_DET_IDX ? det_q : mreg_q[maddr];
	assign ser.sclk_fall = sclk_fall && !single;
	assign ser.rd_act = !pin_s2_q[MRA_P_RD];
	assign ser.rd_fall = rd_fall;
	assign ser.wr_rise = wr_rise;
	assign ser.din = pin_s2_q[MRA_P_DIN];
	assign ser.rdata = ser_rdata;

	mra_ser_eng u_eng (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.s(ser)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ser_data_oe_n <= 1'b1;
			ser_data_o <= 1'b0;
		end else if (ce) begin
			ser_data_oe_n <= !(!single && !pin_s2_q[MRA_P_RD]);
			ser_data_o <= ser.dout && !single && !pin_s2_q[MRA_P_RD];
		end
	end
endmodule

// ### tb/mra_top_chk.sv
// checker: port-level properties of the modem register access block
// assumes: bound to mra_top, ce held high by the bench
`timescale 1ns/100ps
module mra_top_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic port_mode_select,
	input wire logic rd_n,
	input wire logic ser_data_oe_n,
	input wire logic device_reset_in,
	input wire logic processor_reset_out,
	input wire logic uart_irq_in,
	input wire logic uart_irq_out,
	input wire logic [7:0] modem_detect_flags,
	input wire logic modem_irq_out,
	input wire logic dtr_n,
	input wire logic rts_n,
	input wire logic host_chip_sel
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	property p_rdy; hreadyout && !hresp; endproperty
	a_rdy: assert property (p_rdy) else $error("bus stall");
	property p_oe_off; rd_n[*5] |-> ser_data_oe_n; endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin driven");
	property p_oe_on; (!rd_n && !port_mode_select)[*6] |-> !ser_data_oe_n;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("pin not driven");
	property p_prst; device_reset_in[*4] |-> processor_reset_out; endproperty
	a_prst: assert property (p_prst) else $error("no cpu reset");
	property p_uirq; uart_irq_in |-> uart_irq_out; endproperty
	a_uirq: assert property (p_uirq) else $error("uart irq lost");
	property p_mirq;
		!port_mode_select[*5] ##1 $changed(modem_detect_flags)
			|-> ##[1:3] modem_irq_out;
	endproperty
	a_mirq: assert property (p_mirq) else $error("no modem irq");
	property p_mirq_sp; port_mode_select[*5] |-> !modem_irq_out; endproperty
	a_mirq_sp: assert property (p_mirq_sp) else $error("modem irq");
	property p_hs_dp; !port_mode_select[*5] |-> dtr_n && rts_n; endproperty
	a_hs_dp: assert property (p_hs_dp) else $error("handshake out");
	property p_cs_dp; !port_mode_select[*5] |-> !host_chip_sel; endproperty
	a_cs_dp: assert property (p_cs_dp) else $error("chip sel");
	c_irq: cover property (modem_irq_out ##1 !modem_irq_out);
	c_rd: cover property (!ser_data_oe_n);
	c_cs: cover property (host_chip_sel);
endmodule
bind mra_top mra_top_chk i_chk (.hclk, .hresetn, .hreadyout, .hresp,
	.port_mode_select, .rd_n, .ser_data_oe_n, .device_reset_in,
	.processor_reset_out, .uart_irq_in, .uart_irq_out, .modem_detect_flags,
	.modem_irq_out, .dtr_n, .rts_n, .host_chip_sel);

// ### tb/mra_proc_model.sv
// model: modem control processor on the serial command port
// assumes: bit clock of 800 ns, standing high between frames
`timescale 1ns/100ps
module mra_proc_model (
	output logic sclk,
	output logic rd_n,
	output logic wr_n,
	output logic [2:0] ma,
	output logic dq,
	input wire logic din
);
	// handshake lines live on the processor's own ports, not here
	initial begin
		sclk = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		ma = 3'h0;
		dq = 1'b0;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		#13 ma = a;
		for (int i = 0; i < 8; i++) begin
			dq = d[i];
			#400 sclk = 1'b0;
			#400 sclk = 1'b1;
		end
		dq = ~dq;
		#400 wr_n = 1'b0;
		#800 wr_n = 1'b1;
		#800;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		#13 ma = a;
		rd_n = 1'b0;
		#600;
		for (int i = 0; i < 8; i++) begin
			d[i] = din;
			#200 sclk = 1'b0;
			#400 sclk = 1'b1;
			#200;
		end
		rd_n = 1'b1;
		#800;
	endtask
endmodule

// ### tb/modem_register_access_ports_test.sv
// testbench: register bus, handshake pins and serial command port
// assumes: mra_top with its bound checker, processor model on serial pins
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module modem_register_access_ports_test;
	import mra_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, pms = 1, rd_ph = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2, ma, rsel;
	logic als_n = 1, cs_n = 1, cts_n = 1, dsr_n = 1, dcd_n = 1, ri_n = 1;
	logic dev_rst = 0, uirq = 0;
	logic [3:0] ha = 0;
	logic [7:0] flags = 0, b, r, e;
	logic hreadyout, hresp, dtr_n, rts_n, bsa, hcs, sclk, rd_n, wr_n;
	logic dq, dout, oe_n, uio, mio, prst;
	logic [63:0] q[$];
	int err_count = 0, n_checks = 0, cyc = 0, seed = 25733;
	wire sd = oe_n ? dq : dout;
	always #50 hclk = ~hclk;
	mra_top i_dut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .port_mode_select(pms), .addr_latch_strobe_n(als_n),
		.host_reg_addr(pms ? ha : {ma[2], ha[2:0]}), .chip_select_two_n(cs_n),
		.cts_n, .dsr_n, .dcd_n, .ri_n, .dtr_n, .rts_n, .bank_select_addr(bsa),
		.host_reg_sel(rsel), .host_chip_sel(hcs), .serial_bit_clock(sclk),
		.rd_n, .wr_n, .modem_reg_addr(ma[1:0]), .ser_data_i(sd),
		.ser_data_o(dout), .ser_data_oe_n(oe_n), .device_reset_in(dev_rst),
		.uart_irq_in(uirq), .modem_detect_flags(flags), .uart_irq_out(uio),
		.modem_irq_out(mio), .processor_reset_out(prst));
	mra_proc_model i_proc (.sclk, .rd_n, .wr_n, .ma, .dq, .din(sd));
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc > 20000) begin
			err_count++;
			final_report();
		end else if (rd_ph && hreadyout) begin
			`CHK(hrdata & q[0][63:32], q[0][31:0])
			q.pop_front();
		end
	end
	task automatic wt(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] m);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rd_ph <= !w;
		if (!w)
			q.push_back({m, d & m});
		do @(posedge hclk); while (!hreadyout);
		rd_ph <= 1'b0;
	endtask
	initial begin
		wt(20);
		hresetn <= 1'b1;
		wt(4);
		ahb(0, MRA_HCR_OFS, 0, 32'hff);
		ahb(0, MRA_STAT_OFS, 32'h1, 32'h203);
		ahb(1, 8'h40, 32'hffffffff, 0);
		ahb(0, 8'h40, 0, 32'hffffffff);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			b = 8'($random(seed));
			{dcd_n, ri_n, dsr_n, cts_n} <= b[3:0];
			ahb(1, MRA_HCR_OFS, {27'h0, b[4:0]}, 0);
			ahb(0, MRA_HSR_OFS, {24'h0, ~b[3:0], 4'h0}, 32'hf0);
			ahb(0, MRA_HCR_OFS, {27'h0, b[4:0]}, 32'h1f);
			wt(3);
			`CHK({dtr_n, rts_n, prst}, {~b[0], ~b[1], b[3]})
		end
		ahb(1, MRA_HCR_OFS, 0, 0);
		dev_rst <= 1'b1;
		wt(5);
		`CHK(prst, 1'b1)
		dev_rst <= 1'b0;
		$display("test handshake done");
		for (int i = 0; i < 2; i++) begin
			b = 8'($random(seed));
			ha <= {i[0], b[2:0]};
			cs_n <= b[4];
			als_n <= 1'b0;
			wt(4);
			als_n <= 1'b1;
			wt(6);
			ha <= ~ha;
			cs_n <= ~b[4];
			wt(4);
			`CHK({bsa, rsel, hcs}, {i[0], b[2:0], ~b[4]})
			ahb(0, MRA_STAT_OFS, {23'h0, ~b[4], i[0], b[2:0], 4'h0},
				32'h1f0);
		end
		uirq <= 1'b1;
		wt(1);
		`CHK(uio, 1'b1)
		uirq <= 1'b0;
		flags <= 8'($random(seed)) | 8'h1;
		wt(5);
		`CHK({uio, mio}, 2'b10)
		ahb(0, MRA_DET_OFS, {24'h0, flags}, 32'hff);
		wt(2);
		`CHK(uio, 1'b0)
		$display("test single-port done");
		pms <= 1'b0;
		wt(6);
		`CHK({dtr_n, rts_n, hcs}, 3'b110)
		for (int a = 0; a < 8; a++) begin
			b = 8'($random(seed));
			e = (a == 1) ? flags : b;
			i_proc.wr(a[2:0], b);
			ahb(0, MRA_MREG_OFS + 8'(a * 4), {24'h0, e}, 32'hff);
			i_proc.rd(a[2:0], r);
			`CHK(r, e)
			`CHK(oe_n, 1'b1)
		end
		ahb(1, MRA_MREG_OFS, 32'h5a, 0);
		i_proc.rd(3'h0, r);
		`CHK(r, 8'h5a)
		flags <= flags ^ 8'h81;
		wt(25);
		`CHK(mio, 1'b1)
		i_proc.rd(3'h1, r);
		`CHK(r, flags)
		wt(5);
		`CHK(mio, 1'b0)
		$display("test dual-port done");
		final_report();
	end
endmodule
